// File: hw/lane_cfg_pkg.sv
// constants of the lane 0 configuration register bank
// assumes a 32-bit APB master and four port pairs, one register each
package lane_cfg_pkg;
  localparam int          NPAIR = 4;
  localparam int          AW    = 18;
  // register byte addresses
  localparam logic [17:0] LANE0_CONFIG_MAC_PAIR0_OFS = 18'h130B0;
  localparam logic [17:0] LANE0_CONFIG_MAC_PAIR1_OFS = 18'h132B0;
  localparam logic [17:0] LANE0_CONFIG_MAC_PAIR2_OFS = 18'h134B0;
  localparam logic [17:0] LANE0_CONFIG_MAC_PAIR3_OFS = 18'h136B0;
  localparam logic [17:0] PAIR_CTRL_OFS              = 18'h130C0;
  localparam logic [17:0] PAIR_STAT_OFS              = 18'h130C4;
  // field positions
  localparam int LINE_RATE_BIT = 0;
  localparam int RECALC_BIT    = 1;
  localparam int UNUSED_LSB    = 2;
  localparam int RSVD8_BIT     = 8;
  localparam int TX_EN_LSB     = 9;
  localparam int BOOST_LSB     = 12;
  localparam int PLL_PWR_BIT   = 16;
  localparam int RX_EN_BIT     = 17;
  localparam int DPLL_CLR_BIT  = 18;
  localparam int EQ_LSB        = 21;
  localparam int DPLL_SEL_LSB  = 24;
  localparam int TX_CLK_BIT    = 27;
  localparam int LOS_LSB       = 28;
  localparam int ALIGN_BIT     = 30;
  localparam int RSVD31_BIT    = 31;
  localparam int BYPASS_BIT    = 0;
  localparam int SPEED_LSB     = 4;
  localparam int LOCKED_LSB    = 0;
  localparam int RXACT_LSB     = 4;
  // reset values of the fields
  localparam logic [31:0] UNUSED_RST = 32'h4;
  localparam logic [31:0] TX_EN_RST  = 32'h3;
  localparam logic [31:0] BOOST_RST  = 32'hC;
  localparam logic [31:0] EQ_RST     = 32'h5;
  localparam logic [31:0] ONE_RST    = 32'h1;
  localparam logic [31:0] CFG_RESET  = (UNUSED_RST << UNUSED_LSB)
    | (TX_EN_RST << TX_EN_LSB) | (BOOST_RST << BOOST_LSB)
    | (ONE_RST << PLL_PWR_BIT) | (ONE_RST << RX_EN_BIT)
    | (ONE_RST << DPLL_CLR_BIT) | (EQ_RST << EQ_LSB)
    | (ONE_RST << TX_CLK_BIT) | (ONE_RST << ALIGN_BIT)
    | (ONE_RST << RSVD31_BIT);
  // fields held while bypass is low
  localparam logic [31:0] LOCK_MASK  = (32'h7 << TX_EN_LSB)
    | (ONE_RST << PLL_PWR_BIT) | (ONE_RST << RX_EN_BIT);
endpackage

// File: hw/rise_pulse.sv
// one-cycle pulse on each rising edge of a level vector
// assumes levels come from flip-flops in the same clock domain
`timescale 1ns/10ps
`default_nettype none
module rise_pulse
  import lane_cfg_pkg::*;
#(
  parameter int         W    = 4,
  parameter logic [3:0] INIT = 4'h0
)(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // level in, pulse out
  input  wire logic [W-1:0] level,
  output wire logic [W-1:0] pulse
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic [W-1:0] pls;
  } rp_t;
  rp_t s_r;
  rp_t s_nxt;
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.pls  = level & ~s_r.prev;
    s_nxt.prev = level;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      s_r <= '{prev: INIT[W-1:0], pls: '0};
    else if (ce)
      s_r <= s_nxt;
  end
  assign pulse = s_r.pls;
endmodule // rise_pulse
`default_nettype wire

// File: hw/lane_cfg_merge.sv
// next value of one lane word on a software write
// assumes byte strobes already folded into wr_word
`timescale 1ns/10ps
`default_nettype none
module lane_cfg_merge
  import lane_cfg_pkg::*;
(
  // current word and write
  input  wire logic [31:0] old_word,
  input  wire logic [31:0] wr_word,
  // lock state
  input  wire logic        bypass,
  input  wire logic        pll_locked,
  // result
  output logic      [31:0] new_word
);
  always_comb
  begin
    new_word            = wr_word;
    new_word[RSVD8_BIT] = 1'b0;
    if (!bypass)
      new_word = (new_word & ~LOCK_MASK) | (old_word & LOCK_MASK);
    else if (new_word[RX_EN_BIT] && !old_word[RX_EN_BIT]
             && !(new_word[PLL_PWR_BIT] && pll_locked))
      new_word[RX_EN_BIT] = 1'b0;
  end
endmodule // lane_cfg_merge
`default_nettype wire

// File: hw/lane_cfg_regs.sv
// lane 0 configuration registers of four port pairs on APB
// assumes synchronous inputs, one clock, APB master holding requests
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module lane_cfg_regs
  import lane_cfg_pkg::*;
(
  // clock, reset, enable
  input  wire logic             CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  // APB slave
  input  wire logic             PSEL,
  input  wire logic             PENABLE,
  input  wire logic             PWRITE,
  input  wire logic [AW-1:0]    PADDR,
  input  wire logic [31:0]      PWDATA,
  input  wire logic [3:0]       PSTRB,
  output wire logic [31:0]      PRDATA,
  output wire logic             PREADY,
  output wire logic             PSLVERR,
  // lane status
  input  wire logic [NPAIR-1:0] RX_PLL_LOCKED,
  // lane controls, pair i in slice i
  output wire logic [NPAIR-1:0] HALF_RATE,
  output wire logic [NPAIR-1:0] TX_RECALC_PULSE,
  output wire logic [3*NPAIR-1:0] TX_ENABLE,
  output wire logic [4*NPAIR-1:0] TX_BOOST,
  output wire logic [NPAIR-1:0] RX_PLL_POWER,
  output wire logic [NPAIR-1:0] RX_ENABLE,
  output wire logic [NPAIR-1:0] DPLL_CLEAR_PULSE,
  output wire logic [3*NPAIR-1:0] RX_EQ_LEVEL,
  output wire logic [3*NPAIR-1:0] DPLL_SELECT,
  output wire logic [NPAIR-1:0] TX_CLK_POWER,
  output wire logic [2*NPAIR-1:0] LOSS_DETECT_CTL,
  output wire logic [NPAIR-1:0] ALIGN_ENABLE,
  output wire logic             BYPASS_ACTIVE
);

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [NPAIR-1:0][31:0] cfg;
    logic                   bypass;
    logic [NPAIR-1:0]       speed;
    logic [NPAIR-1:0]       rx_on;
    logic                   ready;
    logic                   err;
    logic [31:0]            rdata;
  } state_t;

  localparam state_t S_RESET = '{
    cfg:    {NPAIR{CFG_RESET}},
    bypass: 1'b0,
    speed:  '0,
    rx_on:  '0,
    ready:  1'b0,
    err:    1'b0,
    rdata:  32'h0000_0000
  };

  localparam logic [NPAIR-1:0][AW-1:0] PAIR_OFS = {
    LANE0_CONFIG_MAC_PAIR3_OFS,
    LANE0_CONFIG_MAC_PAIR2_OFS,
    LANE0_CONFIG_MAC_PAIR1_OFS,
    LANE0_CONFIG_MAC_PAIR0_OFS
  };

  state_t s_r;
  state_t s_nxt;

  // ==========================================================
  // helpers
  // ==========================================================
  // byte strobes to bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++)
    begin
      m[8*b +: 8] = {8{s[b]}};
    end
    return m;
  endfunction

  // strobed write onto an old word
  function automatic logic [31:0] apply_wr(
    input logic [31:0] old_w,
    input logic [31:0] wd,
    input logic [3:0]  s
  );
    logic [31:0] m;
    m = strb_mask(s);
    return (old_w & ~m) | (wd & m);
  endfunction

  // ==========================================================
  // decode
  // ==========================================================
  logic             acc;
  logic             commit;
  logic [NPAIR-1:0] pair_hit;
  logic             ctrl_hit;
  logic             stat_hit;
  logic             any_hit;
  logic [31:0]      rd_mux;
  logic [31:0]      ctrl_word;
  logic [31:0]      stat_word;

  assign acc    = PSEL & PENABLE;
  assign commit = acc & s_r.ready;

  always_comb
  begin
    pair_hit = '0;
    for (int i = 0; i < NPAIR; i++)
    begin
      pair_hit[i] = (PADDR == PAIR_OFS[i]);
    end
  end

  assign ctrl_hit = (PADDR == PAIR_CTRL_OFS);
  assign stat_hit = (PADDR == PAIR_STAT_OFS);
  assign any_hit  = (|pair_hit) | ctrl_hit | stat_hit;

  always_comb
  begin
    ctrl_word = '0;
    ctrl_word[BYPASS_BIT] = s_r.bypass;
    ctrl_word[SPEED_LSB +: NPAIR] = s_r.speed;
    stat_word = '0;
    stat_word[LOCKED_LSB +: NPAIR] = RX_PLL_LOCKED;
    stat_word[RXACT_LSB +: NPAIR] = s_r.rx_on;
  end

  always_comb
  begin
    rd_mux = '0;
    for (int i = 0; i < NPAIR; i++)
    begin
      if (pair_hit[i])
        rd_mux = s_r.cfg[i];
    end
    if (ctrl_hit)
      rd_mux = ctrl_word;
    if (stat_hit)
      rd_mux = stat_word;
  end

  // ==========================================================
  // per-pair write merge
  // ==========================================================
  logic [NPAIR-1:0][31:0] merged;

  for (genvar g = 0; g < NPAIR; g++)
  begin : g_merge
    lane_cfg_merge u_merge (
      .old_word   (s_r.cfg[g]),
      .wr_word    (apply_wr(s_r.cfg[g], PWDATA, PSTRB)),
      .bypass     (s_r.bypass),
      .pll_locked (RX_PLL_LOCKED[g]),
      .new_word   (merged[g])
    );
  end

  // ==========================================================
  // next state
  // ==========================================================
  logic [31:0] ctrl_new;

  assign ctrl_new = apply_wr(ctrl_word, PWDATA, PSTRB);

  always_comb
  begin
    s_nxt       = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.err   = 1'b0;
    s_nxt.rdata = '0;
    // answer one cycle into the access phase
    if (acc && !s_r.ready)
    begin
      s_nxt.ready = 1'b1;
      s_nxt.err   = !any_hit;
      s_nxt.rdata = PWRITE ? 32'h0000_0000 : rd_mux;
    end
    if (commit && PWRITE)
    begin
      for (int i = 0; i < NPAIR; i++)
      begin
        if (pair_hit[i])
          s_nxt.cfg[i] = merged[i];
      end
      if (ctrl_hit)
      begin
        s_nxt.bypass = ctrl_new[BYPASS_BIT];
        s_nxt.speed  = ctrl_new[SPEED_LSB +: NPAIR];
        for (int i = 0; i < NPAIR; i++)
        begin
          s_nxt.cfg[i][LINE_RATE_BIT] = ctrl_new[SPEED_LSB + i];
        end
      end
    end
    for (int i = 0; i < NPAIR; i++)
    begin
      // receive path gated by power and lock
      s_nxt.rx_on[i] = s_r.cfg[i][RX_EN_BIT]
                     & s_r.cfg[i][PLL_PWR_BIT]
                     & RX_PLL_LOCKED[i];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (RST)
      s_r <= S_RESET;
    else if (CE)
      s_r <= s_nxt;
  end

  // ==========================================================
  // edge actions
  // ==========================================================
  logic [NPAIR-1:0] recalc_lvl;
  logic [NPAIR-1:0] dclr_lvl;

  always_comb
  begin
    for (int i = 0; i < NPAIR; i++)
    begin
      recalc_lvl[i] = s_r.cfg[i][RECALC_BIT];
      dclr_lvl[i]   = s_r.cfg[i][DPLL_CLR_BIT];
    end
  end

  rise_pulse #(.W(NPAIR), .INIT(4'h0)) u_recalc (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .level (recalc_lvl),
    .pulse (TX_RECALC_PULSE)
  );

  rise_pulse #(.W(NPAIR), .INIT(4'hF)) u_dclr (
    .clk   (CLK),
    .rst   (RST),
    .ce    (CE),
    .level (dclr_lvl),
    .pulse (DPLL_CLEAR_PULSE)
  );

  // ==========================================================
  // outputs
  // ==========================================================
  assign PRDATA        = s_r.rdata;
  assign PREADY        = s_r.ready;
  assign PSLVERR       = s_r.err;
  assign BYPASS_ACTIVE = s_r.bypass;

  for (genvar g = 0; g < NPAIR; g++)
  begin : g_out
    assign HALF_RATE[g]          = s_r.cfg[g][LINE_RATE_BIT];
    assign TX_ENABLE[3*g +: 3]   = s_r.cfg[g][TX_EN_LSB +: 3];
    assign TX_BOOST[4*g +: 4]    = s_r.cfg[g][BOOST_LSB +: 4];
    assign RX_PLL_POWER[g]       = s_r.cfg[g][PLL_PWR_BIT];
    assign RX_ENABLE[g]          = s_r.rx_on[g];
    assign RX_EQ_LEVEL[3*g +: 3] = s_r.cfg[g][EQ_LSB +: 3];
    assign DPLL_SELECT[3*g +: 3] = s_r.cfg[g][DPLL_SEL_LSB +: 3];
    assign TX_CLK_POWER[g]       = s_r.cfg[g][TX_CLK_BIT];
    assign LOSS_DETECT_CTL[2*g +: 2] = s_r.cfg[g][LOS_LSB +: 2];
    assign ALIGN_ENABLE[g]       = s_r.cfg[g][ALIGN_BIT];
  end

  // ==========================================================
  // assertions
  // ==========================================================
  localparam int ANS_MIN = 1;
  localparam int ANS_MAX = 2;

  logic wr_p0;
  logic wr_ctrl;
  assign wr_p0   = commit && PWRITE && pair_hit[0] && (PSTRB == 4'hF);
  assign wr_ctrl = commit && PWRITE && ctrl_hit && (PSTRB == 4'hF);

  a_apb_answer: assert property (@(posedge CLK) disable iff (RST || !CE)
    $rose(acc) |-> ##[ANS_MIN:ANS_MAX] PREADY)
    else $error("no answer to an access");

  a_ready_single: assert property (@(posedge CLK) disable iff (RST || !CE)
    PREADY |=> !PREADY)
    else $error("ready held too long");

  a_unmapped_err: assert property (@(posedge CLK) disable iff (RST || !CE)
    (acc && !s_r.ready && !any_hit) |=> (PREADY && PSLVERR))
    else $error("unmapped access not flagged");

  a_lock_hold: assert property (@(posedge CLK) disable iff (RST || !CE)
    (wr_p0 && !s_r.bypass) |=> ($stable(TX_ENABLE[2:0])
      && $stable(RX_PLL_POWER[0])))
    else $error("locked field changed without bypass");

  a_bypass_write: assert property (@(posedge CLK) disable iff (RST || !CE)
    (wr_p0 && s_r.bypass) |=> (TX_ENABLE[2:0] == $past(PWDATA[11:9])))
    else $error("bypass write to transmit enable lost");

  a_rx_gate: assert property (@(posedge CLK) disable iff (RST || !CE)
    RX_ENABLE[0] |-> ($past(RX_PLL_LOCKED[0]) && $past(s_r.cfg[0][PLL_PWR_BIT])))
    else $error("receive enabled without power and lock");

  a_recalc_edge: assert property (@(posedge CLK) disable iff (RST || !CE)
    (recalc_lvl[0] && !$past(recalc_lvl[0])) |=> TX_RECALC_PULSE[0] ##1 !TX_RECALC_PULSE[0])
    else $error("recalculation pulse wrong");

  a_dclr_edge: assert property (@(posedge CLK) disable iff (RST || !CE)
    DPLL_CLEAR_PULSE[0] |-> ($past(dclr_lvl[0]) && !$past(dclr_lvl[0], 2)))
    else $error("frequency clear without rising edge");

  a_speed_rate: assert property (@(posedge CLK) disable iff (RST || !CE)
    wr_ctrl |=> (HALF_RATE[0] == $past(PWDATA[SPEED_LSB])))
    else $error("line rate not following speed select");

  a_align_write: assert property (@(posedge CLK) disable iff (RST || !CE)
    wr_p0 |=> (ALIGN_ENABLE[0] == $past(PWDATA[ALIGN_BIT])))
    else $error("alignment write lost");

  c_bypass_write: cover property (@(posedge CLK) disable iff (RST)
    wr_p0 && s_r.bypass);
  c_recalc: cover property (@(posedge CLK) disable iff (RST)
    TX_RECALC_PULSE[0]);
  c_rx_on: cover property (@(posedge CLK) disable iff (RST)
    $rose(RX_ENABLE[0]));
  c_slverr: cover property (@(posedge CLK) disable iff (RST)
    PREADY && PSLVERR);

endmodule // lane_cfg_regs
`default_nettype wire

// File: verif/lane_cfg_regs_tb.sv
// self-checking bench of the lane 0 configuration registers
// assumes an APB slave that answers within twenty cycles, one clock
`timescale 1ns/10ps
`default_nettype none
module lane_cfg_regs_tb
  import lane_cfg_pkg::*;
;
  // ==========================================================
  // signals and model state
  logic                 CLK;
  logic                 RST;
  logic                 CE;
  logic                 PSEL;
  logic                 PENABLE;
  logic                 PWRITE;
  logic [AW-1:0]        PADDR;
  logic [31:0]          PWDATA;
  logic [3:0]           PSTRB;
  logic [31:0]          PRDATA;
  logic                 PREADY;
  logic                 PSLVERR;
  logic [NPAIR-1:0]     RX_PLL_LOCKED;
  logic [NPAIR-1:0]     HALF_RATE;
  logic [NPAIR-1:0]     TX_RECALC_PULSE;
  logic [3*NPAIR-1:0]   TX_ENABLE;
  logic [4*NPAIR-1:0]   TX_BOOST;
  logic [NPAIR-1:0]     RX_PLL_POWER;
  logic [NPAIR-1:0]     RX_ENABLE;
  logic [NPAIR-1:0]     DPLL_CLEAR_PULSE;
  logic [3*NPAIR-1:0]   RX_EQ_LEVEL;
  logic [3*NPAIR-1:0]   DPLL_SELECT;
  logic [NPAIR-1:0]     TX_CLK_POWER;
  logic [2*NPAIR-1:0]   LOSS_DETECT_CTL;
  logic [NPAIR-1:0]     ALIGN_ENABLE;
  logic                 BYPASS_ACTIVE;
  logic [31:0]          mdl [NPAIR];
  logic                 byp;
  logic [3:0]           spd;
  logic                 count_on;
  int                   err_total;
  int                   samples_checked;
  int                   exp_rc;
  int                   exp_dc;
  int                   seen_rc;
  int                   seen_dc;

  lane_cfg_regs i_lane_cfg_regs (
    .CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_PLL_LOCKED(RX_PLL_LOCKED), .HALF_RATE(HALF_RATE),
    .TX_RECALC_PULSE(TX_RECALC_PULSE), .TX_ENABLE(TX_ENABLE), .TX_BOOST(TX_BOOST),
    .RX_PLL_POWER(RX_PLL_POWER), .RX_ENABLE(RX_ENABLE), .DPLL_CLEAR_PULSE(DPLL_CLEAR_PULSE),
    .RX_EQ_LEVEL(RX_EQ_LEVEL), .DPLL_SELECT(DPLL_SELECT), .TX_CLK_POWER(TX_CLK_POWER),
    .LOSS_DETECT_CTL(LOSS_DETECT_CTL), .ALIGN_ENABLE(ALIGN_ENABLE),
    .BYPASS_ACTIVE(BYPASS_ACTIVE)
  );

  always #25 CLK = ~CLK;

  // pulses counted once per high cycle
  always @(posedge CLK)
    if (count_on)
    begin
      seen_rc += $countones(TX_RECALC_PULSE);
      seen_dc += $countones(DPLL_CLEAR_PULSE);
    end

  // ==========================================================
  // expectations
  function automatic logic [31:0] rst_word();
    return (32'h4 << 2) | (32'h3 << 9) | (32'hC << 12) | (32'h7 << 16)
      | (32'h5 << 21) | (32'h1 << 27) | (32'h1 << 30) | (32'h1 << 31);
  endfunction

  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s,
                                        logic b, logic lk);
    logic [31:0] n;
    for (int k = 0; k < 32; k++)
      n[k] = s[k/8] ? d[k] : o[k];
    if (!b)
    begin
      n[11:9] = o[11:9];
      n[17:16] = o[17:16];
    end
    n[8] = 1'h0;
    if (!o[17] && n[17] && !(n[16] && lk))
      n[17] = 1'h0;
    return n;
  endfunction

  function automatic logic [AW-1:0] lane_addr(int i);
    return 18'h130B0 + AW'(i) * 18'h200;
  endfunction

  // ==========================================================
  // bus and compare tasks
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    @(posedge CLK);
    PSEL <= 1'h1;
    PENABLE <= 1'h0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    PSTRB <= s;
    @(posedge CLK);
    PENABLE <= 1'h1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge CLK);
      if (PREADY === 1'h1)
        break;
    end
    if (n == 20)
    begin
      err_total++;
      conclude();
    end
    else
    begin
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
    end
  endtask

  task automatic wr_lane(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic [31:0] o;
    logic        er;
    o = mdl[i];
    apb(1'h1, lane_addr(i), d, s, rd, er);
    chk("lane_write_err", 32'(er), 32'h0);
    mdl[i] = merge(o, d, s, byp, RX_PLL_LOCKED[i]);
    exp_rc += (!o[1] && mdl[i][1]) ? 1 : 0;
    exp_dc += (!o[18] && mdl[i][18]) ? 1 : 0;
  endtask

  task automatic wr_ctrl(input logic b, input logic [3:0] sp);
    logic [31:0] rd;
    logic        er;
    apb(1'h1, PAIR_CTRL_OFS, {24'h0, sp, 3'h0, b}, 4'hF, rd, er);
    byp = b;
    spd = sp;
    // speed select copied to line rate
    for (int i = 0; i < NPAIR; i++)
      mdl[i][0] = sp[i];
  endtask

  task automatic check_all();
    logic [31:0]      rd;
    logic [31:0]      sw;
    logic             er;
    logic [NPAIR-1:0] rxe;
    for (int i = 0; i < NPAIR; i++)
    begin
      apb(1'h0, lane_addr(i), 32'h0, 4'hF, rd, er);
      chk("lane_word", rd, mdl[i]);
      rxe[i] = mdl[i][17] & mdl[i][16] & RX_PLL_LOCKED[i];
    end
    apb(1'h0, PAIR_CTRL_OFS, 32'h0, 4'hF, rd, er);
    chk("ctrl_word", rd, {24'h0, spd, 3'h0, byp});
    apb(1'h0, PAIR_STAT_OFS, 32'h0, 4'hF, rd, er);
    chk("stat_word", rd, {24'h0, rxe, RX_PLL_LOCKED});
    for (int i = 0; i < NPAIR; i++)
    begin
      sw = {1'h0, ALIGN_ENABLE[i], LOSS_DETECT_CTL[2*i+:2], TX_CLK_POWER[i],
            DPLL_SELECT[3*i+:3], RX_EQ_LEVEL[3*i+:3], 4'h0, RX_PLL_POWER[i],
            TX_BOOST[4*i+:4], TX_ENABLE[3*i+:3], 8'h0, HALF_RATE[i]};
      chk("lane_pins", sw, mdl[i] & 32'h7FE1FE01);
    end
    chk("rx_enable", 32'(RX_ENABLE), 32'(rxe));
    chk("bypass", 32'(BYPASS_ACTIVE), 32'(byp));
  endtask

  task automatic reset_tail();
    repeat (3) @(posedge CLK);
    RST <= 1'h0;
    for (int i = 0; i < NPAIR; i++)
      mdl[i] = rst_word();
    byp = 1'h0;
    spd = 4'h0;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] rd;
    logic [31:0] d;
    logic        er;
    int          i;
    CLK = 1'h0;
    RST = 1'h1;
    CE = 1'h1;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = '0;
    PWDATA = 32'h0;
    PSTRB = 4'h0;
    RX_PLL_LOCKED = 4'hB;
    count_on = 1'h0;
    err_total = 0;
    samples_checked = 0;
    seen_rc = 0;
    seen_dc = 0;
    void'($urandom(49));
    reset_tail();
    check_all();
    exp_rc = 0;
    exp_dc = 0;
    count_on = 1'h1;
    apb(1'h1, 18'h130B4, 32'hFFFFFFFF, 4'hF, rd, er);
    chk("unmapped_wr_err", 32'(er), 32'h1);
    apb(1'h0, 18'h130B4, 32'h0, 4'hF, rd, er);
    chk("unmapped_rd_err", 32'(er), 32'h1);
    chk("unmapped_rd_data", rd, 32'h0);
    apb(1'h1, PAIR_STAT_OFS, 32'hFFFFFFFF, 4'hF, rd, er);
    chk("stat_wr_err", 32'(er), 32'h0);
    // locked fields kept without bypass
    wr_lane(0, 32'h88000000, 4'hF);
    check_all();
    // receive enable refused while unlocked
    wr_ctrl(1'h1, 4'h5);
    RX_PLL_LOCKED <= 4'h0;
    wr_lane(1, 32'h88000000, 4'hF);
    wr_lane(1, 32'h88030000, 4'hF);
    wr_lane(2, 32'h88000001, 4'hF);
    wr_lane(2, 32'h88040003, 4'hF);
    check_all();
    for (int k = 0; k < 60; k++)
    begin
      RX_PLL_LOCKED <= 4'($urandom);
      if ($urandom % 5 == 0)
        wr_ctrl(1'($urandom), 4'($urandom));
      else
      begin
        i = $urandom % NPAIR;
        d = $urandom;
        d[0] = mdl[i][0];
        d[27] = 1'h1;
        d[31] = 1'h1;
        if (mdl[i][17])
          d[26:24] = mdl[i][26:24];
        wr_lane(i, d, 4'($urandom));
      end
      if (k % 6 == 5)
        check_all();
    end
    check_all();
    repeat (3) @(posedge CLK);
    chk("recalc_pulses", 32'(seen_rc), 32'(exp_rc));
    chk("dpll_clear_pulses", 32'(seen_dc), 32'(exp_dc));
    count_on = 1'h0;
    RST <= 1'h1;
    reset_tail();
    check_all();
    // clock enable low freezes the receive gate
    rd = 32'(RX_ENABLE);
    CE <= 1'h0;
    RX_PLL_LOCKED <= RX_PLL_LOCKED ^ 4'hE;
    repeat (3) @(posedge CLK);
    chk("ce_freeze", 32'(RX_ENABLE), rd);
    CE <= 1'h1;
    repeat (2) @(posedge CLK);
    chk("ce_resume", 32'(RX_ENABLE), 32'(RX_PLL_LOCKED));
    conclude();
  end
endmodule // lane_cfg_regs_tb
`default_nettype wire
